// >>> core/lie_top.sv
// Interrupt event register of the link controller, with its mask,
// the late-ack enable and the general-purpose interrupt enables.
// Assumes a register master on the same clock that never overlaps
// its strobes, and event sources from core logic on this clock.
`timescale 1ns/1ps
module lie_top
  import lie_pkg::*;
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_ARST_N,
  // Register port
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [DATA_W-1:0] O_RDATA,
  // Event sources from core logic
  input wire logic [31:0] I_EVT_SRC,
  input wire logic I_RX_FIFO_PEND,
  input wire logic I_PHYS_RESP_BUSY,
  input wire logic I_ACK_TARDY_SENT,
  // General-purpose interrupt pins
  input wire logic I_GP_IRQ_A,
  input wire logic I_GP_IRQ_B,
  // Interrupt output
  output logic O_IRQ
);

  // ------------------------------------------------------------
  // Sub-blocks
  // ------------------------------------------------------------
  lie_evt_if evt ();

  lie_sync u_sync (
    .i_clk(I_REF_CLK),
    .i_arst_n(I_ARST_N),
    .evt(evt.sync_mp)
  );

  lie_edge u_edge (
    .i_clk(I_REF_CLK),
    .i_arst_n(I_ARST_N),
    .evt(evt.edge_mp)
  );

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  lie_core_st_t st_ff;
  lie_core_st_t nxt_st;
  logic gp_lvl;
  logic late_lvl;
  logic late_cause;
  logic [31:0] hw_rise;
  logic [31:0] set_bits;
  logic [31:0] clr_bits;
  logic wr_evt_set;
  logic wr_evt_clr;
  logic rd_evt;

  // ------------------------------------------------------------
  // Source levels
  // ------------------------------------------------------------
  assign evt.gp_pin = {I_GP_IRQ_B, I_GP_IRQ_A};

  assign gp_lvl = (evt.gp_sync[0] & st_ff.gpa_en) | (evt.gp_sync[1] & st_ff.gpb_en);

  assign late_cause = I_RX_FIFO_PEND | I_PHYS_RESP_BUSY | I_ACK_TARDY_SENT;

  assign late_lvl = st_ff.late_en & late_cause;

  // no hardware source on bit 29
  always_comb begin
    evt.raw = I_EVT_SRC & EVT_HW_SRC_MASK;
    evt.raw[BIT_GP_EVT] = gp_lvl;
    evt.raw[BIT_LATE_ACK] = late_lvl;
  end

  assign hw_rise = evt.rise & EVT_IMPL_MASK;

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  assign wr_evt_set = I_WR && (I_ADDR == OFS_EVT_SET);
  assign wr_evt_clr = I_WR && (I_ADDR == OFS_EVT_CLR);
  assign rd_evt = I_ADDR == OFS_EVT_SET || I_ADDR == OFS_EVT_CLR;

  assign set_bits = wr_evt_set ? (I_WDATA & EVT_IMPL_MASK) : 32'h0000_0000;

  assign clr_bits = wr_evt_clr ? (I_WDATA & EVT_IMPL_MASK) : 32'h0000_0000;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ev = ((st_ff.ev & ~clr_bits) | hw_rise | set_bits) & EVT_IMPL_MASK;
    if (I_WR) begin
      case (I_ADDR)
        OFS_MASK_SET: begin
          nxt_st.mask = (st_ff.mask | I_WDATA) & EVT_IMPL_MASK;
        end
        OFS_MASK_CLR: begin
          nxt_st.mask = st_ff.mask & ~I_WDATA;
        end
        OFS_HC_CTRL_SET: begin
          if (I_WDATA[BIT_LATE_ACK_EN]) begin
            nxt_st.late_en = 1'b1;
          end
        end
        OFS_HC_CTRL_CLR: begin
          if (I_WDATA[BIT_LATE_ACK_EN]) begin
            nxt_st.late_en = 1'b0;
          end
        end
        OFS_GPIO_CTRL: begin
          nxt_st.gpa_en = I_WDATA[BIT_GP_A_EN];
          nxt_st.gpb_en = I_WDATA[BIT_GP_B_EN];
        end
        default: begin
          nxt_st.mask = st_ff.mask;
        end
      endcase
    end
    // Read data stands only in the cycle after the strobe
    nxt_st.rdata = RD_UNMAPPED;
    if (I_RD) begin
      if (rd_evt) begin
        nxt_st.rdata = st_ff.ev & st_ff.mask;
      end else begin
        case (I_ADDR)
          OFS_MASK_SET, OFS_MASK_CLR: begin
            nxt_st.rdata = st_ff.mask;
          end
          OFS_HC_CTRL_SET, OFS_HC_CTRL_CLR: begin
            nxt_st.rdata[BIT_LATE_ACK_EN] = st_ff.late_en;
          end
          OFS_GPIO_CTRL: begin
            nxt_st.rdata[BIT_GP_A_EN] = st_ff.gpa_en;
            nxt_st.rdata[BIT_GP_B_EN] = st_ff.gpb_en;
          end
          default: begin
            nxt_st.rdata = RD_UNMAPPED;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_ff <= '{ev: EVT_RST, mask: MASK_RST, late_en: 1'b0, gpa_en: 1'b0,
                 gpb_en: 1'b0, rdata: RDATA_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign O_RDATA = st_ff.rdata;
  assign O_IRQ = |(st_ff.ev & st_ff.mask);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence seq_set_wr;
    I_WR && I_ADDR == OFS_EVT_SET;
  endsequence

  sequence seq_clr_wr;
    I_WR && I_ADDR == OFS_EVT_CLR;
  endsequence

  sequence seq_evt_rd;
    I_RD && (I_ADDR == OFS_EVT_SET || I_ADDR == OFS_EVT_CLR);
  endsequence

  sequence seq_late_new;
    st_ff.late_en && !$past(late_lvl);
  endsequence

  a_edge_sets_bit: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (|hw_rise) |=> ((st_ff.ev & $past(hw_rise)) == $past(hw_rise)))
    else $error("source edge did not set its event bit");

  a_set_alias_write: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    seq_set_wr |=> ((st_ff.ev & ($past(I_WDATA) & EVT_IMPL_MASK))
                    == ($past(I_WDATA) & EVT_IMPL_MASK)))
    else $error("set alias write did not set bits");

  a_clear_only_alias: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (|($past(st_ff.ev) & ~st_ff.ev)) |-> $past(I_WR && I_ADDR == OFS_EVT_CLR))
    else $error("event bit fell without a clear write");

  a_read_masked: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    seq_evt_rd |=> (O_RDATA == $past(st_ff.ev & st_ff.mask)))
    else $error("event read not ANDed with mask");

  a_gp_event_set: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    $rose(gp_lvl) |=> st_ff.ev[BIT_GP_EVT])
    else $error("gp interrupt did not set bit 30");

  a_gp_enable_gate: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    $rose(st_ff.ev[BIT_GP_EVT]) |->
      $past((evt.gp_sync[0] && st_ff.gpa_en) || (evt.gp_sync[1] && st_ff.gpb_en))
      || $past(I_WR && I_ADDR == OFS_EVT_SET && I_WDATA[BIT_GP_EVT]))
    else $error("bit 30 set with its gp input disabled");

  a_soft_from_write: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    $rose(st_ff.ev[BIT_SW_EVT]) |-> $past(I_WR && I_ADDR == OFS_EVT_SET
                                          && I_WDATA[BIT_SW_EVT]))
    else $error("bit 29 set without a set alias write");

  a_rsvd_read_zero: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    seq_evt_rd |=> (!O_RDATA[BIT_RSVD_HI] && !O_RDATA[BIT_RSVD_LO])[*2])
    else $error("reserved event bit read as one");

  a_late_ack_gate: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    $rose(st_ff.ev[BIT_LATE_ACK]) |-> $past(st_ff.late_en && late_cause)
      || $past(I_WR && I_ADDR == OFS_EVT_SET && I_WDATA[BIT_LATE_ACK]))
    else $error("bit 27 set without enable and cause");

  a_late_ack_set: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    $rose(late_lvl) ##1 1'b1 |-> st_ff.ev[BIT_LATE_ACK])
    else $error("enabled late ack cause did not set bit 27");

  a_set_beats_clear: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (seq_clr_wr ##0 (|(hw_rise & clr_bits)))
      |=> ((st_ff.ev & $past(hw_rise & clr_bits)) == $past(hw_rise & clr_bits)))
    else $error("clear write lost a same-cycle event");

  // ------------------------------------------------------------
  // Checks on aliases, causes and reset
  // ------------------------------------------------------------
  // clear alias clears bits
  a_clear_alias_clears: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    seq_clr_wr |=> ((st_ff.ev & $past(I_WDATA & ~hw_rise)) == 32'h0000_0000))
    else $error("clear alias write left a bit set");

  a_set_alias_keeps: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    seq_set_wr |=> ((st_ff.ev & ~$past(I_WDATA))
                    == ($past(st_ff.ev | hw_rise) & ~$past(I_WDATA))))
    else $error("set alias write changed an unwritten bit");

  a_rsvd_never_set: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    !st_ff.ev[BIT_RSVD_HI] && !st_ff.ev[BIT_RSVD_LO]
      && !st_ff.mask[BIT_RSVD_HI] && !st_ff.mask[BIT_RSVD_LO])
    else $error("reserved bit stored as one");

  a_late_ack_off: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (!st_ff.late_en && !(I_WR && I_ADDR == OFS_EVT_SET && I_WDATA[BIT_LATE_ACK]))
      |=> !$rose(st_ff.ev[BIT_LATE_ACK]))
    else $error("bit 27 set while late ack is disabled");

  a_rx_pend_cause: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (seq_late_new ##0 I_RX_FIFO_PEND) |=> st_ff.ev[BIT_LATE_ACK])
    else $error("pending receive data did not set bit 27");

  a_resp_busy_cause: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (seq_late_new ##0 I_PHYS_RESP_BUSY) |=> st_ff.ev[BIT_LATE_ACK])
    else $error("busy response unit did not set bit 27");

  a_tardy_cause: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    (seq_late_new ##0 I_ACK_TARDY_SENT) |=> st_ff.ev[BIT_LATE_ACK])
    else $error("sent late ack did not set bit 27");

  a_rdata_idle: assert property (
    @(posedge I_REF_CLK) disable iff (!I_ARST_N)
    !$past(I_RD) |-> (O_RDATA == RD_UNMAPPED))
    else $error("read data stood without a read");

  a_reset_values: assert property (
    @(posedge I_REF_CLK)
    $rose(I_ARST_N) |-> (st_ff.ev == EVT_RST && st_ff.mask == MASK_RST
                          && O_RDATA == RDATA_RST && !O_IRQ))
    else $error("state not cleared by reset");

endmodule : lie_top

// >>> common/lie_pkg.sv
// Constants and state types of the link interrupt event block.
// Assumes a single 100 MHz clock and a plain register port.
package lie_pkg;

  // ------------------------------------------------------------
  // Register port geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_HC_CTRL_SET = 8'h50;
  localparam logic [7:0] OFS_HC_CTRL_CLR = 8'h54;
  localparam logic [7:0] OFS_EVT_SET = 8'h80;
  localparam logic [7:0] OFS_EVT_CLR = 8'h84;
  localparam logic [7:0] OFS_MASK_SET = 8'h88;
  localparam logic [7:0] OFS_MASK_CLR = 8'h8c;
  localparam logic [7:0] OFS_GPIO_CTRL = 8'hfc;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_RSVD_HI = 31;
  localparam int BIT_GP_EVT = 30;
  localparam int BIT_SW_EVT = 29;
  localparam int BIT_RSVD_LO = 28;
  localparam int BIT_LATE_ACK = 27;
  localparam int BIT_LATE_ACK_EN = 29;
  localparam int BIT_GP_B_EN = 31;
  localparam int BIT_GP_A_EN = 23;

  // ------------------------------------------------------------
  // Bit masks and reset values
  // ------------------------------------------------------------
  localparam logic [31:0] EVT_IMPL_MASK = 32'h6fff_83ff;
  localparam logic [31:0] EVT_HW_SRC_MASK = 32'h07ff_83ff;
  localparam logic [31:0] EVT_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  localparam logic [1:0] SYNC_RST = 2'h0;
  localparam logic [31:0] PREV_RST = 32'h0000_0000;

  // ------------------------------------------------------------
  // State types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ev;
    logic [31:0] mask;
    logic late_en;
    logic gpa_en;
    logic gpb_en;
    logic [31:0] rdata;
  } lie_core_st_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } lie_sync_st_t;

  typedef struct packed {
    logic [31:0] prev;
  } lie_edge_st_t;

endpackage : lie_pkg

// >>> common/lie_evt_if.sv
// Carrier between the event core, the pin synchroniser and the edge finder.
// Assumes all three sit on one clock.
`timescale 1ns/1ps
interface lie_evt_if;
  logic [1:0] gp_pin;
  logic [1:0] gp_sync;
  logic [31:0] raw;
  logic [31:0] rise;

  modport sync_mp (input gp_pin, output gp_sync);
  modport edge_mp (input raw, output rise);
  modport core_mp (output gp_pin, output raw, input gp_sync, input rise);
endinterface : lie_evt_if

// >>> core/lie_sync.sv
// Two-stage synchroniser for the general-purpose interrupt pins.
// Assumes the pins are asynchronous to the clock.
`timescale 1ns/1ps
module lie_sync
  import lie_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Pins in, levels out
  lie_evt_if.sync_mp evt
);
  lie_sync_st_t st_ff;
  lie_sync_st_t nxt_st;

  // ------------------------------------------------------------
  // Per-bit stages
  // ------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_bit
    assign evt.gp_sync[g] = st_ff.s2[g];
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = evt.gp_pin;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= '{s1: SYNC_RST, s2: SYNC_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : lie_sync

// >>> core/lie_edge.sv
// Rising-edge finder over the 32 event source levels.
// Assumes levels already live in the clock domain.
`timescale 1ns/1ps
module lie_edge
  import lie_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Levels in, one-cycle edges out
  lie_evt_if.edge_mp evt
);
  lie_edge_st_t st_ff;
  lie_edge_st_t nxt_st;

  // ------------------------------------------------------------
  // Per-bit edge
  // ------------------------------------------------------------
  for (genvar g = 0; g < 32; g++) begin : g_bit
    assign evt.rise[g] = evt.raw[g] & ~st_ff.prev[g];
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev = evt.raw;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= '{prev: PREV_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : lie_edge

// >>> verification/lie_top_tb.sv
// Self-checking bench of the link interrupt event register.
// Assumes lie_pkg, lie_evt_if and the core modules are compiled first.
`timescale 1ns/1ps
module link_interrupt_event_register_tb
  import lie_pkg::*;
();
  // ------------------------------------------------------------
  // Clock, reset and design ports
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] evt_src = 32'h0000_0000;
  logic rx_pend = 1'b0;
  logic resp_busy = 1'b0;
  logic tardy = 1'b0;
  logic gp_a = 1'b0;
  logic gp_b = 1'b0;
  logic irq;
  int errors = 0;
  int checked = 0;

  always #5 clk = ~clk;

  lie_top DUT (
    .I_REF_CLK(clk),
    .I_ARST_N(arst_n),
    .I_ADDR(addr),
    .I_WDATA(wdata),
    .I_WR(wr),
    .I_RD(rd),
    .O_RDATA(rdata),
    .I_EVT_SRC(evt_src),
    .I_RX_FIFO_PEND(rx_pend),
    .I_PHYS_RESP_BUSY(resp_busy),
    .I_ACK_TARDY_SENT(tardy),
    .I_GP_IRQ_A(gp_a),
    .I_GP_IRQ_B(gp_b),
    .O_IRQ(irq)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stands one cycle only, then returns to zero
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
    @(negedge clk);
    chk(rdata, 32'h0000_0000);
  endtask : rd_chk

  task automatic wrap_up;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    wr_reg(OFS_MASK_SET, 32'hffff_ffff);
    rd_chk(OFS_MASK_SET, EVT_IMPL_MASK);
    rd_chk(OFS_EVT_CLR, 32'h0000_0000);
    chk(32'(irq), 32'h0);
    rd_chk(8'h40, RD_UNMAPPED);
  endtask : t_reset

  task automatic t_soft;
    wr_reg(OFS_EVT_SET, 32'h2000_0000);
    rd_chk(OFS_EVT_SET, 32'h2000_0000);
    chk(32'(irq), 32'h1);
    wr_reg(OFS_EVT_SET, 32'h0000_0001);
    rd_chk(OFS_EVT_SET, 32'h2000_0001);
    wr_reg(OFS_EVT_SET, 32'hffff_ffff);
    rd_chk(OFS_EVT_CLR, EVT_IMPL_MASK);
    wr_reg(OFS_EVT_CLR, 32'h0000_0001);
    rd_chk(OFS_EVT_SET, 32'h6fff_83fe);
    wr_reg(OFS_MASK_CLR, 32'h6fff_83fe);
    rd_chk(OFS_EVT_SET, 32'h0000_0000);
    chk(32'(irq), 32'h0);
    wr_reg(8'h40, 32'hffff_ffff);
    wr_reg(OFS_MASK_SET, 32'h2000_0000);
    rd_chk(OFS_EVT_SET, 32'h2000_0000);
    chk(32'(irq), 32'h1);
    wr_reg(OFS_MASK_SET, 32'hffff_ffff);
    rd_chk(OFS_EVT_SET, 32'h6fff_83fe);
    wr_reg(OFS_EVT_CLR, 32'hffff_ffff);
    rd_chk(OFS_EVT_SET, 32'h0000_0000);
    chk(32'(irq), 32'h0);
  endtask : t_soft

  // Every source held high gives one event per bit of EVT_HW_SRC_MASK
  task automatic t_hw;
    @(posedge clk);
    evt_src <= 32'hffff_ffff;
    repeat (3) @(posedge clk);
    rd_chk(OFS_EVT_SET, EVT_HW_SRC_MASK);
    wr_reg(OFS_EVT_CLR, 32'hffff_ffff);
    repeat (3) @(posedge clk);
    rd_chk(OFS_EVT_SET, 32'h0000_0000);
    @(posedge clk);
    evt_src <= 32'h0000_0000;
  endtask : t_hw

  task automatic t_late;
    @(posedge clk);
    {tardy, resp_busy, rx_pend} <= 3'h7;
    repeat (3) @(posedge clk);
    rd_chk(OFS_EVT_SET, 32'h0000_0000);
    @(posedge clk);
    {tardy, resp_busy, rx_pend} <= 3'h0;
    wr_reg(OFS_HC_CTRL_SET, 32'hffff_ffff);
    rd_chk(OFS_HC_CTRL_SET, 32'h2000_0000);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      {tardy, resp_busy, rx_pend} <= 3'h1 << i;
      repeat (3) @(posedge clk);
      rd_chk(OFS_EVT_SET, 32'h0800_0000);
      @(posedge clk);
      {tardy, resp_busy, rx_pend} <= 3'h0;
      wr_reg(OFS_EVT_CLR, 32'h0800_0000);
    end
    wr_reg(OFS_HC_CTRL_CLR, 32'h2000_0000);
    rd_chk(OFS_HC_CTRL_CLR, 32'h0000_0000);
  endtask : t_late

  task automatic gp_pulse(input logic [1:0] ba, input logic [31:0] exp);
    @(posedge clk);
    {gp_b, gp_a} <= ba;
    repeat (4) @(posedge clk);
    {gp_b, gp_a} <= 2'h0;
    repeat (4) @(posedge clk);
    rd_chk(OFS_EVT_SET, exp);
    wr_reg(OFS_EVT_CLR, 32'h4000_0000);
  endtask : gp_pulse

  task automatic t_gp;
    gp_pulse(2'h3, 32'h0000_0000);
    wr_reg(OFS_GPIO_CTRL, 32'h0080_0000);
    gp_pulse(2'h1, 32'h4000_0000);
    gp_pulse(2'h2, 32'h0000_0000);
    wr_reg(OFS_GPIO_CTRL, 32'h8000_0000);
    rd_chk(OFS_GPIO_CTRL, 32'h8000_0000);
    gp_pulse(2'h2, 32'h4000_0000);
    gp_pulse(2'h1, 32'h0000_0000);
  endtask : t_gp

  // Source edge and clear write land on the same edge
  task automatic t_race;
    @(posedge clk);
    evt_src <= 32'h0000_0001;
    addr <= OFS_EVT_CLR;
    wdata <= 32'h0000_0001;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd_chk(OFS_EVT_SET, 32'h0000_0001);
    chk(32'(irq), 32'h1);
    @(posedge clk);
    evt_src <= 32'h0000_0000;
  endtask : t_race

  // Reset in mid-run with events, the mask and all three enables set
  task automatic t_mid_reset;
    wr_reg(OFS_GPIO_CTRL, 32'h8080_0000);
    wr_reg(OFS_HC_CTRL_SET, 32'h2000_0000);
    wr_reg(OFS_EVT_SET, 32'h2000_0000);
    @(negedge clk);
    chk(32'(irq), 32'h1);
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    chk(32'(irq), 32'h0);
    chk(rdata, RDATA_RST);
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(OFS_MASK_SET, MASK_RST);
    wr_reg(OFS_MASK_SET, 32'hffff_ffff);
    rd_chk(OFS_EVT_SET, EVT_RST);
    rd_chk(OFS_HC_CTRL_SET, 32'h0000_0000);
    rd_chk(OFS_GPIO_CTRL, 32'h0000_0000);
  endtask : t_mid_reset

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_soft();
    t_hw();
    t_late();
    t_gp();
    t_race();
    t_mid_reset();
    wrap_up();
  end

  initial begin
    #50us;
    errors++;
    wrap_up();
  end
endmodule : link_interrupt_event_register_tb
